// ### hdl/drive_monitor_regs.svh
/*
  register offsets, field positions, reset values and timing counts
  for the drive monitor meters and display block.
  assumes the includer sits in a 200 MHz aclk domain.
*/
`ifndef DRIVE_MONITOR_REGS_SVH
`define DRIVE_MONITOR_REGS_SVH

// register byte offsets
`define OFS_CTRL       8'h00
`define OFS_PARAM      8'h04
`define OFS_CLEAR      8'h08
`define OFS_INPUTS     8'h0C
`define OFS_FREQ       8'h10
`define OFS_THERMAL    8'h14
`define OFS_POWER      8'h18
`define OFS_POWERON    8'h1C
`define OFS_RUNTIME    8'h20
`define OFS_WRAPS      8'h24
`define OFS_ENERGY     8'h28
`define OFS_ENERGY2    8'h2C
`define OFS_PANEL      8'h30
`define OFS_HANDHELD   8'h34
`define OFS_COMM       8'h38
`define OFS_STATUS     8'h3C

// ctrl fields
`define CTRL_RUN       0
`define CTRL_FAULT     1
`define CTRL_MRS       2
`define CTRL_KEY       3

// parameter values
`define SEL_ROTATE     16'h0000
`define SEL_IOMON      16'h0037
`define SEL_ENERGY     16'h0019
`define SEL_SETFREQ    16'h0064
`define VAL_9999       16'h270F
`define VAL_10         16'h000A
`define HOUR_MAX       16'hFFFF
`define PANEL_MAX      16'h270F
`define PANEL_HOURS    16'h0FFF

// reset values
`define RST_SEL        16'h0000
`define RST_ECLR       16'h270F
`define RST_SHIFT      16'h270F
`define RST_RCLR       16'h270F

// timing: clock 200 MHz
`define CLK_MHZ        200
`define HOUR_S         3600
`define KEY_HOLD_MS    1000
`define HOUR_CYCLES    (64'(`HOUR_S) * `CLK_MHZ * 1000000)
`define KEY_CYCLES     (`KEY_HOLD_MS * `CLK_MHZ * 1000)

`endif

// ### hdl/drive_monitor_pkg.sv
/*
  types shared by the drive monitor block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package drive_monitor_pkg;

  typedef enum logic [3:0] {
    MON_FIRST = 4'b0001,
    MON_SECOND = 4'b0010,
    MON_THIRD = 4'b0100,
    MON_FAULT = 4'b1000
  } mon_slot_e;

  typedef struct packed {
    logic [15:0] poweron;
    logic [15:0] runtime;
    logic [15:0] poweron_wraps;
    logic [15:0] runtime_wraps;
  } hours_s;

  typedef struct packed {
    logic [15:0] panel;
    logic [19:0] handheld;
    logic [15:0] comm;
  } energy_view_s;

endpackage

// ### hdl/drive_monitor_meters.sv
/*
  drive monitor meters and display: hour counters, energy accumulator,
  panel/handheld/communication formatting, exposed as an axi4-lite slave.
  assumes a single 200 MHz aclk, synchronous active-low aresetn, and that
  the drive core writes its live measurements into the input registers.
*/
// Operation
// - hour counters count 0 to 65535 then wrap
// - panel hours scaled 0.001, max 65.53, restart
// - sub-hour running remainder lost at power-off
// - panel shows dashes beyond four digits
// - thermal monitor shows larger of two
// - select zero: key steps full sequence
// - chosen item sits in third slot
// - power-up first monitor; hold key sets it (reset always shows MON_FIRST; the held slot only follows MON_FAULT)
// - select 100: set/output freq, Hz blinks
// - set frequency shown after limits and jumps
// - fault holds frequency captured at fault
// - output stop behaves as stopped display
// - select 55: terminal segments, centre lit
// - energy integrates power, refreshes hourly
// - panel energy resolution steps to 9999
// - handheld energy resolution steps to 99999
// - comm energy 1kWh ranges, second 0.01kWh
// - energy shifted right by digit shift
// - clamp for shift 0-4, wrap for 9999
// - write 0 clears energy, reads nonzero
// - wrap counters count hour counter wraps
// - runtime clear on 0; no poweron clear
`timescale 1ns/1ps
`include "drive_monitor_regs.svh"

module drive_monitor_meters
  import drive_monitor_pkg::*;
#(
  parameter longint HOUR_CYC = `HOUR_CYCLES,
  parameter longint KEY_CYC = `KEY_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // panel indicators
  output logic hz_led,
  output logic [3:0] panel_slot
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] ctrl_r;
  logic [15:0] sel_r, shift_r, eclr_r, rclr_r;
  logic [15:0] setf_r, maxf_r, minf_r, jlo_r, jhi_r;
  logic [15:0] outf_r, fault_f_r, mth_r, tth_r, pwr_r;
  logic [15:0] in_term_r, out_term_r;
  hours_s hrs_r;
  logic [63:0] on_cnt_r, run_cnt_r, key_cnt_r;
  logic [63:0] e_acc_r;
  logic [31:0] e_tot_r;
  logic [31:0] rdata_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic fault_d_r, key_d_r, key_done_r;
  logic [25:0] blink_r;
  mon_slot_e slot_r, first_r;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] div10(input logic [31:0] v, input logic [15:0] n);
    logic [31:0] r;
    r = v;
    for (int i = 0; i < 4; i++) begin
      if (i < n) begin
        r = r / 32'd10;
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= `OFS_STATUS) && (a[1:0] == 2'b00);
  endfunction

  // panel hours: 1 h shows as 0.001, so 65530 h reads 65.53 and then restarts
  // from zero; both hour counters go through the same scaling
  function automatic logic [15:0] hrs_pan(input logic [15:0] h);
    logic [15:0] w;
    w = h > 16'd65530 ? h - 16'd65531 : h;
    return w / 16'd10;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi write path
  wire do_write = aw_have_r && w_have_r && !bvalid_r;
  wire [7:0] wa = awaddr_r;
  wire [15:0] wv = wdata_r[15:0];
  wire wr_ctrl = do_write && wa == `OFS_CTRL;
  wire wr_param = do_write && wa == `OFS_PARAM;
  wire wr_clear = do_write && wa == `OFS_CLEAR;
  wire wr_inputs = do_write && wa == `OFS_INPUTS;
  wire wr_freq = do_write && wa == `OFS_FREQ;
  wire wr_therm = do_write && wa == `OFS_THERMAL;
  wire wr_power = do_write && wa == `OFS_POWER;
  // a zero written to either clear half clears that meter; any other value
  // only changes what the half reads back, save that 10 in the energy half also wraps the comm energy at 9999 kWh
  wire ecl_hit = wr_clear && wdata_r[15:0] == 16'h0000;
  wire rcl_hit = wr_clear && wdata_r[31:16] == 16'h0000;

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // capture address and data in either order, answer once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(wa) ? 2'b00 : 2'b10;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // software-written configuration and drive measurements
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 4'h0;
      sel_r <= `RST_SEL;
      shift_r <= `RST_SHIFT;
      {setf_r, maxf_r, minf_r, jlo_r, jhi_r} <= '0;
      {outf_r, mth_r, tth_r, pwr_r, in_term_r, out_term_r} <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata_r[3:0];
      if (wr_param) begin
        sel_r <= wdata_r[15:0];
        shift_r <= wdata_r[31:16];
      end
      if (wr_inputs) {out_term_r, in_term_r} <= wdata_r;
      if (wr_freq) {setf_r, outf_r} <= wdata_r;
      if (wr_therm) {tth_r, mth_r} <= wdata_r;
      if (wr_power) {maxf_r, pwr_r} <= wdata_r;
      if (do_write && wa == `OFS_STATUS) {jhi_r, jlo_r} <= wdata_r;
      if (do_write && wa == `OFS_PANEL) minf_r <= wv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hour counters
  wire running = ctrl_r[`CTRL_RUN] && !ctrl_r[`CTRL_MRS];
  wire on_tick = on_cnt_r == HOUR_CYC - 1;
  wire run_tick = running && run_cnt_r == HOUR_CYC - 1;

  // power-on hours have no clear; running remainder lives only in flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_cnt_r <= 64'h0;
      run_cnt_r <= 64'h0;
      hrs_r <= '0;
      rclr_r <= `RST_RCLR;
    end else begin
      on_cnt_r <= on_tick ? 64'h0 : on_cnt_r + 64'h1;
      if (running) begin
        run_cnt_r <= run_tick ? 64'h0 : run_cnt_r + 64'h1;
      end
      if (on_tick) begin
        hrs_r.poweron <= hrs_r.poweron + 16'h1;
        if (hrs_r.poweron == `HOUR_MAX) hrs_r.poweron_wraps <= hrs_r.poweron_wraps + 16'h1;
      end
      if (rcl_hit) begin
        hrs_r.runtime <= 16'h0;
        run_cnt_r <= 64'h0;
      end else if (run_tick) begin
        hrs_r.runtime <= hrs_r.runtime + 16'h1;
        if (hrs_r.runtime == `HOUR_MAX) hrs_r.runtime_wraps <= hrs_r.runtime_wraps + 16'h1;
      end
      if (wr_clear) rclr_r <= `VAL_9999;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // energy accumulator: power in 0.01 kW summed per cycle, total per hour
  // the tick cycle's own power joins the sum, so an hour spans HOUR_CYC samples;
  // 64 bits hold a full hour of the largest power reading without overflow
  wire [63:0] e_hour = e_acc_r + 64'(pwr_r);
  wire [31:0] e_next = e_tot_r + 32'(e_hour / 64'(HOUR_CYC));
  // a digit shift of 0 to 4 saturates at the top, any other setting wraps to zero
  wire clamp_mode = shift_r <= 16'd4;
  wire [31:0] e_max = 32'd9999999; // 99999.99 kWh in 0.01 units

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_acc_r <= 64'h0;
      e_tot_r <= 32'h0;
      eclr_r <= `RST_ECLR;
    end else if (ecl_hit) begin
      e_acc_r <= 64'h0;
      e_tot_r <= 32'h0;
      eclr_r <= `VAL_9999;
    end else begin
      e_acc_r <= on_tick ? 64'h0 : e_hour;
      if (on_tick) begin
        if (e_next > e_max) e_tot_r <= clamp_mode ? e_max : e_next - e_max - 32'd1;
        else e_tot_r <= e_next;
      end
      if (wr_clear && wv != 16'h0) eclr_r <= (wv == `VAL_10) ? `VAL_10 : `VAL_9999;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // energy views for panel, handheld and communication
  wire [31:0] e_sh = div10(e_tot_r, clamp_mode ? shift_r : 16'd0);
  wire [31:0] e_pan = e_sh > 32'd999999 ? 32'd999999 : e_sh;
  // panel: 0.01 up to 99.99, 0.1 to 999.9, 1 to 9999
  wire [15:0] pan_e = e_pan < 32'd10000 ? 16'(e_pan) :
                      e_pan < 32'd100000 ? 16'(e_pan / 10) : 16'(e_pan / 100);
  // handheld: 0.01 up to 999.99, 0.1 to 9999.9, 1 to 99999
  wire [19:0] hh_e = e_sh < 32'd100000 ? 20'(e_sh) :
                     e_sh < 32'd1000000 ? 20'(e_sh / 10) : 20'(e_sh / 100);
  wire [31:0] c_kwh = e_sh / 100;
  wire [15:0] com_e = eclr_r == `VAL_10 ? 16'(c_kwh % 10000) : 16'(c_kwh);
  energy_view_s ev;
  assign ev = '{panel: pan_e, handheld: hh_e, comm: com_e};

  ////////////////////////////////////////////////////////////////////////////
  // monitor selection and panel value
  wire stopped = !ctrl_r[`CTRL_RUN] || ctrl_r[`CTRL_MRS];
  wire [15:0] lim_f = setf_r > maxf_r ? maxf_r : setf_r < minf_r ? minf_r : setf_r;
  wire [15:0] eff_set = (lim_f > jlo_r && lim_f < jhi_r) ? jlo_r : lim_f;
  wire [15:0] live_f = ctrl_r[`CTRL_FAULT] ? fault_f_r : outf_r;
  wire [15:0] freq_v = (sel_r == `SEL_SETFREQ && stopped) ? eff_set : live_f;
  wire [15:0] therm = mth_r > tth_r ? mth_r : tth_r;
  wire [15:0] hours_v = hrs_pan(hrs_r.poweron);
  wire [15:0] run_v = hrs_pan(hrs_r.runtime);
  wire [15:0] iomon = {in_term_r[6:0], 1'b1, out_term_r[6:0], 1'b0};
  wire [15:0] third_v = sel_r == `SEL_IOMON ? iomon :
                        sel_r == `SEL_ENERGY ? ev.panel :
                        sel_r == 16'd20 ? hours_v :
                        sel_r == 16'd23 ? run_v : therm;
  wire [15:0] cur_v = slot_r == MON_FIRST ? freq_v :
                      slot_r == MON_SECOND ? pwr_r :
                      slot_r == MON_THIRD ? third_v : 16'h0;
  wire over4 = slot_r != MON_THIRD || sel_r != `SEL_IOMON ? cur_v > `PANEL_MAX : 1'b0;
  wire [15:0] panel_v = over4 ? 16'hFFFF : cur_v;
  // a press that reaches the hold time is spent on the promotion, so its
  // release does not also step the panel
  wire key = ctrl_r[`CTRL_KEY];
  wire key_rel = key_d_r && !key;
  wire key_long = key && key_cnt_r == KEY_CYC - 1;

  // slot rotation on key release, long press promotes slot to first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_r <= MON_FIRST;
      first_r <= MON_FIRST;
      key_d_r <= 1'b0;
      key_cnt_r <= 64'h0;
      key_done_r <= 1'b0;
      fault_d_r <= 1'b0;
      fault_f_r <= 16'h0;
      blink_r <= 26'h0;
    end else begin
      key_d_r <= key;
      fault_d_r <= ctrl_r[`CTRL_FAULT];
      blink_r <= blink_r + 26'h1;
      if (ctrl_r[`CTRL_FAULT] && !fault_d_r) fault_f_r <= outf_r;
      key_cnt_r <= key ? (key_long ? key_cnt_r : key_cnt_r + 64'h1) : 64'h0;
      if (key_long && !key_done_r) begin
        first_r <= slot_r;
        key_done_r <= 1'b1;
      end
      if (key_rel) begin
        key_done_r <= 1'b0;
        if (!key_done_r) begin
          case (slot_r)
            MON_FIRST: slot_r <= MON_SECOND;
            MON_SECOND: slot_r <= MON_THIRD;
            MON_THIRD: slot_r <= MON_FAULT;
            MON_FAULT: slot_r <= first_r;
            default: slot_r <= MON_FIRST;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators
  assign hz_led = slot_r == MON_FIRST && (stopped && sel_r == `SEL_SETFREQ ?
                  blink_r[25] : 1'b1);
  assign panel_slot = slot_r;

  ////////////////////////////////////////////////////////////////////////////
  // axi read path
  // an unmapped or unaligned word answers with an error and zero data
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_mux =
    ra == `OFS_CTRL ? {28'h0, ctrl_r} :
    ra == `OFS_PARAM ? {shift_r, sel_r} :
    ra == `OFS_CLEAR ? {rclr_r, eclr_r} :
    ra == `OFS_INPUTS ? {out_term_r, in_term_r} :
    ra == `OFS_FREQ ? {setf_r, outf_r} :
    ra == `OFS_THERMAL ? {therm, 16'h0} :
    ra == `OFS_POWER ? {maxf_r, pwr_r} :
    ra == `OFS_POWERON ? {16'h0, hrs_r.poweron} :
    ra == `OFS_RUNTIME ? {16'h0, hrs_r.runtime} :
    ra == `OFS_WRAPS ? {hrs_r.runtime_wraps, hrs_r.poweron_wraps} :
    ra == `OFS_ENERGY ? {16'h0, ev.comm} :
    ra == `OFS_ENERGY2 ? e_sh :
    ra == `OFS_PANEL ? {minf_r, panel_v} :
    ra == `OFS_HANDHELD ? {12'h0, ev.handheld} :
    ra == `OFS_COMM ? {eff_set, freq_v} :
    ra == `OFS_STATUS ? {jhi_r, jlo_r} : 32'h0;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // one-cycle read answer, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'b00;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= mapped(ra) ? rd_mux : 32'h0;
      rresp_r <= mapped(ra) ? 2'b00 : 2'b10;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// ### bench/drive_monitor_meters_asserts.sv
/*
  port-level checks for the drive monitor meters block.
  assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module drive_monitor_meters_asserts
  import drive_monitor_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read handshakes
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // panel
  input wire logic hz_led,
  input wire logic [3:0] panel_slot
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // bus steps
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  AST_WR_RESP: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RD_RESP: assert property (read_taken |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_ERR: assert property (read_taken ##0
    (s_axi_araddr > 8'h3C || s_axi_araddr[1:0] != 2'b00)
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");

  ////////////////////////////////////////////////////////////////////////////
  // panel slot rotation
  AST_SLOT_ONEHOT: assert property ($onehot(panel_slot))
    else $error("slot not one-hot");
  AST_SLOT_STEP: assert property ($changed(panel_slot) && $past(panel_slot) != MON_FAULT
    |-> panel_slot == ($past(panel_slot) << 1))
    else $error("slot skipped");
  AST_RESET_SLOT: assert property ($rose(aresetn) |-> panel_slot == MON_FIRST)
    else $error("slot not first after reset");
  AST_RESET_HZ: assert property ($rose(aresetn) |-> hz_led)
    else $error("hz indicator dark after reset");
endmodule

// ### bench/axi_lite_host.sv
/*
  axi4-lite host standing in for the panel and communication master.
  assumes aclk from the bench; the slave answers in its own time.
*/
`timescale 1ns/1ps
module axi_lite_host (
  // clock
  input wire logic aclk,
  // write
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end

  // address and data offered together; released lines show garbage
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read address held until arready is sampled, rready until rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ### bench/test_drive_monitor_meters.sv
/*
  self-checking bench for the drive monitor meters block.
  assumes the host model drives the bus; hour and key counts shortened.
*/
`timescale 1ns/1ps
module test_drive_monitor_meters
  import drive_monitor_pkg::*;
;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] m, e;} row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hz_led;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, e2;
  logic [3:0] s_axi_wstrb, panel_slot;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int num_errors = 0;
  int tests_run = 0;
  // write-then-read rows; mask 0 skips the read, address FF skips the write
  row_s rows [20] = '{
    '{8'hFF, 32'h0, 8'h04, 32'hFFFF_FFFF, 32'h270F_0000},
    '{8'hFF, 32'h0, 8'h08, 32'hFFFF_FFFF, 32'h270F_270F},
    '{8'h14, 32'h0050_0030, 8'h14, 32'hFFFF_0000, 32'h0050_0000},
    '{8'h14, 32'h0020_0070, 8'h14, 32'hFFFF_0000, 32'h0070_0000},
    '{8'h18, 32'h1000_0000, 8'h00, 32'h0, 32'h0},
    '{8'h30, 32'h0000_0100, 8'h00, 32'h0, 32'h0},
    '{8'h3C, 32'h0600_0400, 8'h00, 32'h0, 32'h0},
    '{8'h10, 32'h0500_1234, 8'h00, 32'h0, 32'h0},
    '{8'h00, 32'h0000_0005, 8'h38, 32'hFFFF_0000, 32'h0400_0000},
    '{8'h04, 32'h0000_0064, 8'h38, 32'h0000_FFFF, 32'h0000_0400},
    '{8'h00, 32'h0000_0001, 8'h38, 32'h0000_FFFF, 32'h0000_1234},
    '{8'h00, 32'h0000_0003, 8'h00, 32'h0, 32'h0},
    '{8'h10, 32'h0500_2222, 8'h38, 32'h0000_FFFF, 32'h0000_1234},
    '{8'h00, 32'h0000_0000, 8'h00, 32'h0, 32'h0},
    '{8'h08, 32'h0000_270F, 8'h08, 32'hFFFF_FFFF, 32'h270F_270F},
    '{8'hFF, 32'h0, 8'h20, 32'h0000_FFFF, 32'h0},
    '{8'h08, 32'h270F_0000, 8'h2C, 32'hFFFF_FFFF, 32'h0},
    '{8'hFF, 32'h0, 8'h08, 32'h0000_FFFF, 32'h0000_270F},
    '{8'h18, 32'h3000_0000, 8'h00, 32'h0, 32'h0},
    '{8'h10, 32'h2800_0000, 8'h30, 32'h0000_FFFF, 32'h0000_FFFF}};

  // clock, 5 ns period
  always #2.5 aclk = ~aclk;

  drive_monitor_meters #(.HOUR_CYC(1), .KEY_CYC(40)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .hz_led(hz_led),
    .panel_slot(panel_slot));
  axi_lite_host host (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  ////////////////////////////////////////////////////////////////////////////
  // compare, read-and-compare, key press, verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.rd(a, v, resp);
    chk($sformatf("reg %h", a), e, v & m);
  endtask
  task automatic key(input int hold);
    host.wr(8'h00, 32'h0000_0008, resp);
    repeat (hold) @(posedge aclk);
    host.wr(8'h00, 32'h0000_0000, resp);
    repeat (2) @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well past the long hour run
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    tally_and_finish;
  end

  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wa !== 8'hFF) host.wr(rows[i].wa, rows[i].wd, resp);
      if (rows[i].m !== 32'h0) rdchk(rows[i].ra, rows[i].m, rows[i].e);
    end
    $display("test rows done");
    repeat (50) @(posedge aclk);
    rdchk(8'h20, 32'h0000_FFFF, 32'h0);
    host.wr(8'h00, 32'h0000_0001, resp);
    repeat (66000) @(posedge aclk);
    host.wr(8'h00, 32'h0000_0000, resp);
    rdchk(8'h24, 32'hFFFF_FFFF, 32'h0001_0001);
    host.rd(8'h1C, v, resp);
    chk("poweron small", 32'h1, {31'h0, v[15:0] < 16'h1000});
    $display("test hours done");
    host.wr(8'h00, 32'h0000_0001, resp);
    host.wr(8'h18, 32'h1000_2710, resp);
    repeat (300) @(posedge aclk);
    host.wr(8'h18, 32'h1000_0000, resp);
    host.wr(8'h00, 32'h0000_0000, resp);
    host.rd(8'h2C, e2, resp);
    chk("energy grew", 32'h1, {31'h0, e2 > 32'h0});
    rdchk(8'h28, 32'hFFFF_FFFF, e2 / 100);
    host.wr(8'h08, 32'h270F_000A, resp);
    rdchk(8'h08, 32'h0000_FFFF, 32'h0000_000A);
    host.wr(8'h04, 32'h0002_0017, resp);
    rdchk(8'h28, 32'hFFFF_FFFF, e2 / 10000);
    rdchk(8'h2C, 32'hFFFF_FFFF, e2 / 100);
    rdchk(8'h34, 32'hFFFF_FFFF, e2 / 100);
    $display("test energy done");
    key(0);
    key(0);
    chk("slot", {28'h0, MON_THIRD}, {28'h0, panel_slot});
    host.rd(8'h20, v, resp);
    rdchk(8'h30, 32'h0000_FFFF, {16'h0, v[15:0] / 16'd10});
    host.wr(8'h04, 32'h0002_0019, resp);
    rdchk(8'h30, 32'h0000_FFFF, e2 / 1000);
    key(0);
    chk("slot", {28'h0, MON_FAULT}, {28'h0, panel_slot});
    key(0);
    chk("slot", {28'h0, MON_FIRST}, {28'h0, panel_slot});
    key(0);
    key(60);
    chk("slot", {28'h0, MON_SECOND}, {28'h0, panel_slot});
    repeat (3) key(0);
    chk("slot", {28'h0, MON_SECOND}, {28'h0, panel_slot});
    $display("test panel done");
    host.rd(8'h40, v, resp);
    chk("rresp", 32'h2, {30'h0, resp});
    chk("rdata", 32'h0, v);
    host.wr(8'h44, 32'h0000_0001, resp);
    chk("bresp", 32'h2, {30'h0, resp});
    $display("test unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("slot", {28'h0, MON_FIRST}, {28'h0, panel_slot});
    chk("hz", 32'h1, {31'h0, hz_led});
    $display("test reset done");
    tally_and_finish;
  end
endmodule

bind drive_monitor_meters drive_monitor_meters_asserts chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .hz_led(hz_led),
  .panel_slot(panel_slot));
